// File: rtl/divide_pkg.sv
// Constants, types and state layout for the decimal divide sequencer
// What this block does
// - Gather eight high-order dividend bytes before trial subtraction.
// - Dividend of eight bytes or fewer is fetched whole; longer, only eight high bytes.
// - Divisor high word goes through adder latch, low word to local save.
// - Request high-order dividend doubleword; buffer pointer set from address low bits.
// - Copy dividend bytes high first; step both pointers, decrement dividend length.
// - Dividend length zero before pointers reach 7 means dividend fully adjusted.
// - Buffer pointer reaching 7 first triggers fetch of further dividend bytes.
// - Saved original length codes restored into length hold bits 8-15.
// - Divisor rebuilt in operand buffer pair; both operands left-aligned.
// - Trial subtract; negative continues, positive raises decimal divide exception.
// - Divisor aligned to dividend top byte, then shifted right one digit.
// - Dividend minus divisor length gives maximum quotient bytes.
// - Extra low digit fetched into result byte; high nibble inserted low.
// - Repeated subtraction counts quotient digit, checked, placed in result high nibble.
// - Equal lengths after left digit: sign inserted, quotient byte then remainder stored.
// - Unequal lengths: next digit into low nibble, byte stored, next left digit begins.
// - Flags for nonzero divisor, negative divisor, invalid, negative dividend, hot carry.
// - Short-dividend flag set when dividend is shorter than eight bytes.
// - Low dividend fetched first, counter advanced by divisor length, divisor requested.
// - Dividend sign tested, negative flag pulsed, address lowered, working pointer from divisor length.
// - Long-divisor flag for five bytes or more; clear skips low word rebuild.
// - Divisor length code uses four bits, 0000 to 0111 for one to eight bytes.
// - After last trial cycle, carry out of top bit means positive, instruction ends.
package divide_pkg;

	// Register map, byte addresses
	localparam logic [7:0]  REG_CTRL       = 8'h00;
	localparam logic [7:0]  REG_LENGTHS    = 8'h04;
	localparam logic [7:0]  REG_DVD_ADDR   = 8'h08;
	localparam logic [7:0]  REG_DVSR_ADDR  = 8'h0C;
	localparam logic [7:0]  REG_STATUS     = 8'h10;
	localparam logic [7:0]  REG_HOLD       = 8'h14;
	localparam int          CTRL_START_BIT = 0;

	// Lengths, pointers, steps and digit codes
	localparam logic [3:0]  LEN_EIGHT_BYTES = 4'h7;
	localparam logic [3:0]  LEN_FIVE_BYTES  = 4'h4;
	localparam logic [2:0]  PTR_FIRST       = 3'h0;
	localparam logic [2:0]  PTR_LAST        = 3'h7;
	localparam logic [23:0] DW_STEP         = 24'h000008;
	localparam logic [23:0] BYTE_STEP       = 24'h000001;
	localparam int          DIGIT_SHIFT     = 4;
	localparam logic [3:0]  DIGIT_MAX       = 4'h9;
	localparam logic [3:0]  DIGIT_TEN       = 4'hA;
	localparam logic [3:0]  SIGN_PLUS       = 4'hC;
	localparam logic [3:0]  SIGN_MINUS      = 4'hD;
	localparam logic [3:0]  SIGN_MINUS_ALT  = 4'hB;

	typedef enum logic [4:0] {
		S_IDLE, S_FETCH_LO, S_FETCH_DVSR, S_SIGN, S_DVSR_ADJ, S_DVSR_REFETCH, S_DVSR_SAVE,
		S_DVD_WAIT, S_DVD_COPY, S_RESTORE, S_ASSEMBLE, S_TRIAL, S_SHIFT, S_DIGIT_WAIT,
		S_GEN_START, S_GEN, S_DIGIT, S_STORE_Q, S_STORE_R
	} seq_state_t;

	typedef struct packed {
		logic nonzero_dvsr;
		logic neg_dvsr;
		logic short_dvd;
		logic invalid;
		logic neg_dvd;
		logic long_dvsr;
		logic hot_carry;
	} flags_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} bus_req_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [23:0] addr;
		logic [7:0]  wdata;
	} storage_req_t;

	typedef struct packed {
		seq_state_t   state;
		flags_t       flags;
		logic         dvd_minus;
		logic         first_byte;
		logic         right_phase;
		logic         last_byte;
		logic         half;
		logic         done;
		logic         ovf_fault;
		logic         spec_fault;
		logic [3:0]   dvd_len;
		logic [3:0]   dvsr_len;
		logic [15:0]  len_hold;
		logic [7:0]   result_byte;
		logic [3:0]   pending;
		logic [3:0]   qdigit;
		logic [3:0]   q_left;
		logic [2:0]   wptr;
		logic [2:0]   bptr;
		logic [2:0]   sub_ptr;
		logic [2:0]   store_idx;
		logic [23:0]  operand_addr;
		logic [23:0]  instr_ctr;
		logic [23:0]  dvd_next_addr;
		logic [23:0]  lo_addr;
		logic [31:0]  adder_latch;
		logic [31:0]  lsave;
		logic [63:0]  wp;
		logic [63:0]  buf_pair;
		storage_req_t req;
		logic [7:0]   cfg_lens;
		logic [23:0]  cfg_dvd_addr;
		logic [23:0]  cfg_dvsr_addr;
		logic [31:0]  rdata;
	} seq_regs_t;

endpackage : divide_pkg

// File: rtl/bcd_byte_subtractor.sv
// Serial adder: one packed-decimal byte subtraction with carry chain
`timescale 1ns/1ps
module bcd_byte_subtractor
	import divide_pkg::*;
(
	// Operands
	input  wire logic [7:0] minuend,
	input  wire logic [7:0] subtrahend,
	input  wire logic       carry_in,
	// Result
	output logic [7:0]      difference,
	output logic            carry_out,
	output logic            invalid_digit
);

	logic [2:0] carry;
	logic [1:0] bad;

	assign carry[0] = carry_in;

	// One decimal digit per pass, low digit first; carry high means no borrow
	for (genvar i = 0; i < 2; i++) begin : g_digit
		logic [3:0] m;
		logic [3:0] s;
		logic [4:0] raw;
		assign m = minuend[4*i +: 4];
		assign s = subtrahend[4*i +: 4];
		assign raw = {1'b0, m} - {1'b0, s} - {4'h0, ~carry[i]};
		assign difference[4*i +: 4] = raw[4] ? (raw[3:0] + DIGIT_TEN) : raw[3:0];
		assign carry[i+1] = ~raw[4];
		assign bad[i] = (m > DIGIT_MAX) || (s > DIGIT_MAX);
	end

	assign carry_out     = carry[2];
	assign invalid_digit = |bad;

endmodule : bcd_byte_subtractor

// File: rtl/decimal_divide_sequencer.sv
// Packed-decimal divide sequencer: operand fetch, trial subtraction, quotient generation
`timescale 1ns/1ps
module decimal_divide_sequencer
	import divide_pkg::*;
(
	// Clock and reset
	input  wire logic            clk,
	input  wire logic            resetn,
	// Register port
	input  wire bus_req_t        reg_bus,
	output logic [31:0]          reg_rdata,
	// Main storage
	output storage_req_t         storage_req,
	input  wire logic            storage_ack,
	input  wire logic [63:0]     storage_data_out_bus,
	// Status
	output logic                 busy,
	output logic                 divide_exception
);

	seq_regs_t r_reg;
	seq_regs_t r_next;

	logic [7:0] sa_a;
	logic [7:0] sa_b;
	logic [7:0] sa_diff;
	logic       sa_cout;
	logic       sa_inv;

	function automatic logic [7:0] get_byte(input logic [63:0] v, input logic [2:0] idx);
		get_byte = v[(6'd63 - {idx, 3'b000}) -: 8];
	endfunction : get_byte

	function automatic logic [63:0] put_byte(input logic [63:0] v, input logic [2:0] idx, input logic [7:0] b);
		logic [63:0] t;
		t = v;
		t[(6'd63 - {idx, 3'b000}) -: 8] = b;
		return t;
	endfunction : put_byte

	// Top byte of a subtract pass: divisor bytes plus the shifted-out digit
	function automatic logic [2:0] sub_top(input logic [3:0] len);
		sub_top = (len >= LEN_EIGHT_BYTES) ? PTR_LAST : 3'(len + 4'h1);
	endfunction : sub_top

	function automatic logic sign_neg(input logic [3:0] s);
		sign_neg = (s == SIGN_MINUS) || (s == SIGN_MINUS_ALT);
	endfunction : sign_neg

	// Serial adder selects the addressed byte of each register pair
	assign sa_a = get_byte(r_reg.wp, r_reg.sub_ptr);
	assign sa_b = get_byte(r_reg.buf_pair, r_reg.sub_ptr);

	bcd_byte_subtractor u_serial_adder (
		.minuend       (sa_a),
		.subtrahend    (sa_b),
		.carry_in      (r_reg.flags.hot_carry),
		.difference    (sa_diff),
		.carry_out     (sa_cout),
		.invalid_digit (sa_inv)
	);

	// Next-state logic for the whole sequencer and its registers
	always_comb begin
		logic [7:0]  b;
		logic [7:0]  rb;
		logic        all_fetched;
		logic [63:0] rem;
		b = 8'h00;
		rb = 8'h00;
		r_next = r_reg;
		r_next.rdata = 32'h0;
		all_fetched = r_reg.flags.short_dvd || (r_reg.dvd_next_addr > r_reg.lo_addr);
		rem = r_reg.wp << DIGIT_SHIFT;

		// Register port; read data stands only in the following cycle
		if (reg_bus.rd) begin
			unique case (reg_bus.addr)
				REG_LENGTHS:   r_next.rdata = {24'h0, r_reg.cfg_lens};
				REG_DVD_ADDR:  r_next.rdata = {8'h00, r_reg.cfg_dvd_addr};
				REG_DVSR_ADDR: r_next.rdata = {8'h00, r_reg.cfg_dvsr_addr};
				REG_STATUS:    r_next.rdata = {21'h0, r_reg.flags, r_reg.spec_fault, r_reg.ovf_fault,
					r_reg.done, (r_reg.state != S_IDLE)};
				REG_HOLD:      r_next.rdata = {8'h00, r_reg.len_hold, r_reg.result_byte};
				default:       r_next.rdata = 32'h0;
			endcase
		end
		if (reg_bus.wr && (r_reg.state == S_IDLE)) begin
			unique case (reg_bus.addr)
				REG_LENGTHS:   r_next.cfg_lens = reg_bus.wdata[7:0];
				REG_DVD_ADDR:  r_next.cfg_dvd_addr = reg_bus.wdata[23:0];
				REG_DVSR_ADDR: r_next.cfg_dvsr_addr = reg_bus.wdata[23:0];
				default:       ;
			endcase
		end

		// A request is held until storage acknowledges it
		if (r_reg.req.valid && storage_ack) begin
			r_next.req.valid = 1'b0;
		end

		unique case (r_reg.state)
			S_IDLE: begin
				if (reg_bus.wr && (reg_bus.addr == REG_CTRL) && reg_bus.wdata[CTRL_START_BIT]) begin
					r_next.flags = '0;
					r_next.done = 1'b0;
					r_next.ovf_fault = 1'b0;
					r_next.spec_fault = 1'b0;
					r_next.dvd_len = r_reg.cfg_lens[7:4];
					r_next.dvsr_len = r_reg.cfg_lens[3:0];
					r_next.operand_addr = r_reg.cfg_dvd_addr;
					r_next.lo_addr = r_reg.cfg_dvd_addr;
					r_next.instr_ctr = r_reg.cfg_dvsr_addr;
					r_next.req = '{valid: 1'b1, write: 1'b0, addr: r_reg.cfg_dvd_addr, wdata: 8'h00};
					r_next.state = S_FETCH_LO;
				end
			end
			S_FETCH_LO: begin
				if (storage_ack) begin
					r_next.wp = storage_data_out_bus;
					r_next.instr_ctr = r_reg.instr_ctr + {20'h0, r_reg.dvsr_len};
					r_next.req = '{valid: 1'b1, write: 1'b0, addr: r_reg.instr_ctr + {20'h0, r_reg.dvsr_len},
						wdata: 8'h00};
					r_next.state = S_FETCH_DVSR;
				end
			end
			S_FETCH_DVSR: begin
				if (storage_ack) begin
					r_next.buf_pair = storage_data_out_bus;
					r_next.wptr = r_reg.operand_addr[2:0];
					r_next.result_byte = {r_reg.dvd_len, r_reg.dvsr_len};
					r_next.bptr = PTR_LAST;
					r_next.instr_ctr = r_reg.instr_ctr - DW_STEP;
					r_next.state = S_SIGN;
				end
			end
			S_SIGN: begin
				// Dividend sign sits in the low nibble of the low-order byte
				b = get_byte(r_reg.wp, r_reg.wptr);
				r_next.flags.invalid = (b[3:0] <= DIGIT_MAX);
				r_next.flags.neg_dvd = sign_neg(b[3:0]);
				r_next.dvd_minus = sign_neg(b[3:0]);
				r_next.operand_addr = r_reg.operand_addr - {20'h0, r_reg.dvd_len};
				r_next.wptr = r_reg.dvsr_len[2:0];
				r_next.bptr = r_reg.instr_ctr[2:0];
				r_next.flags.long_dvsr = (r_reg.dvsr_len >= LEN_FIVE_BYTES);
				r_next.wp = 64'h0;
				r_next.first_byte = 1'b1;
				if ((r_reg.dvsr_len > LEN_EIGHT_BYTES) || (r_reg.dvsr_len >= r_reg.dvd_len)) begin
					r_next.spec_fault = 1'b1;
					r_next.done = 1'b1;
					r_next.state = S_IDLE;
				end else begin
					r_next.state = S_DVSR_ADJ;
				end
			end
			S_DVSR_ADJ: begin
				// Divisor copied low byte first into its left-adjusted place
				r_next.flags.neg_dvd = 1'b0;
				b = get_byte(r_reg.buf_pair, r_reg.bptr);
				if (r_reg.first_byte) begin
					r_next.flags.neg_dvsr = sign_neg(b[3:0]);
					if (b[3:0] <= DIGIT_MAX) r_next.flags.invalid = 1'b1;
					b[3:0] = 4'h0;
				end else if (b[3:0] > DIGIT_MAX) begin
					r_next.flags.invalid = 1'b1;
				end
				if (b[7:4] > DIGIT_MAX) r_next.flags.invalid = 1'b1;
				if (b != 8'h00) r_next.flags.nonzero_dvsr = 1'b1;
				r_next.first_byte = 1'b0;
				r_next.wp = put_byte(r_reg.wp, r_reg.wptr, b);
				r_next.wptr = r_reg.wptr - 3'h1;
				r_next.bptr = r_reg.bptr - 3'h1;
				if (r_reg.dvsr_len == 4'h0) begin
					r_next.state = S_DVSR_SAVE;
				end else begin
					r_next.dvsr_len = r_reg.dvsr_len - 4'h1;
					if (r_reg.bptr == PTR_FIRST) begin
						r_next.req = '{valid: 1'b1, write: 1'b0, addr: r_reg.instr_ctr, wdata: 8'h00};
						r_next.instr_ctr = r_reg.instr_ctr - DW_STEP;
						r_next.state = S_DVSR_REFETCH;
					end
				end
			end
			S_DVSR_REFETCH: begin
				if (storage_ack) begin
					r_next.buf_pair = storage_data_out_bus;
					r_next.bptr = PTR_LAST;
					r_next.state = S_DVSR_ADJ;
				end
			end
			S_DVSR_SAVE: begin
				// Free the working pair for the dividend
				r_next.adder_latch = r_reg.wp[63:32];
				r_next.lsave = r_reg.wp[31:0];
				r_next.wp = 64'h0;
				r_next.wptr = PTR_FIRST;
				r_next.flags.short_dvd = (r_reg.dvd_len < LEN_EIGHT_BYTES);
				r_next.dvd_next_addr = r_reg.operand_addr;
				r_next.req = '{valid: 1'b1, write: 1'b0, addr: r_reg.operand_addr, wdata: 8'h00};
				r_next.state = S_DVD_WAIT;
			end
			S_DVD_WAIT: begin
				if (storage_ack) begin
					r_next.buf_pair = storage_data_out_bus;
					r_next.bptr = r_reg.dvd_next_addr[2:0];
					r_next.state = S_DVD_COPY;
				end
			end
			S_DVD_COPY: begin
				b = get_byte(r_reg.buf_pair, r_reg.bptr);
				if (r_reg.dvd_len == 4'h0) b[3:0] = 4'h0;
				r_next.wp = put_byte(r_reg.wp, r_reg.wptr, b);
				r_next.wptr = r_reg.wptr + 3'h1;
				r_next.bptr = r_reg.bptr + 3'h1;
				r_next.dvd_next_addr = r_reg.dvd_next_addr + BYTE_STEP;
				if (r_reg.dvd_len != 4'h0) r_next.dvd_len = r_reg.dvd_len - 4'h1;
				if ((r_reg.dvd_len == 4'h0) || (r_reg.wptr == PTR_LAST)) begin
					r_next.state = S_RESTORE;
				end else if (r_reg.bptr == PTR_LAST) begin
					r_next.req = '{valid: 1'b1, write: 1'b0, addr: r_reg.dvd_next_addr + BYTE_STEP,
						wdata: 8'h00};
					r_next.state = S_DVD_WAIT;
				end
			end
			S_RESTORE: begin
				r_next.len_hold[15:8] = r_reg.result_byte;
				r_next.dvd_len = r_reg.result_byte[7:4];
				r_next.dvsr_len = r_reg.result_byte[3:0];
				r_next.state = S_ASSEMBLE;
			end
			S_ASSEMBLE: begin
				// Rebuild and right-shift the divisor one digit
				r_next.buf_pair = {r_reg.adder_latch, (r_reg.flags.long_dvsr ? r_reg.lsave : 32'h0)}
					>> DIGIT_SHIFT;
				r_next.sub_ptr = sub_top(r_reg.dvsr_len);
				r_next.flags.hot_carry = 1'b1;
				r_next.q_left = r_reg.dvd_len - r_reg.dvsr_len;
				r_next.half = 1'b0;
				r_next.right_phase = 1'b0;
				r_next.last_byte = 1'b0;
				r_next.state = S_TRIAL;
			end
			S_TRIAL: begin
				r_next.flags.hot_carry = sa_cout;
				if (sa_inv) r_next.flags.invalid = 1'b1;
				if (r_reg.sub_ptr == PTR_FIRST) begin
					if (sa_cout || !r_reg.flags.nonzero_dvsr) begin
						r_next.ovf_fault = 1'b1;
						r_next.done = 1'b1;
						r_next.state = S_IDLE;
					end else begin
						r_next.state = S_SHIFT;
					end
				end else begin
					r_next.sub_ptr = r_reg.sub_ptr - 3'h1;
				end
			end
			S_SHIFT: begin
				r_next.qdigit = 4'h0;
				if (all_fetched) begin
					r_next.wp = r_reg.wp << DIGIT_SHIFT;
					r_next.state = S_GEN_START;
				end else if (r_reg.half) begin
					r_next.wp = {r_reg.wp[59:0], r_reg.pending};
					r_next.half = 1'b0;
					r_next.dvd_next_addr = r_reg.dvd_next_addr + BYTE_STEP;
					r_next.state = S_GEN_START;
				end else begin
					r_next.req = '{valid: 1'b1, write: 1'b0, addr: r_reg.dvd_next_addr, wdata: 8'h00};
					r_next.state = S_DIGIT_WAIT;
				end
			end
			S_DIGIT_WAIT: begin
				if (storage_ack) begin
					b = get_byte(storage_data_out_bus, r_reg.dvd_next_addr[2:0]);
					r_next.result_byte = b;
					r_next.wp = {r_reg.wp[59:0], b[7:4]};
					r_next.pending = (r_reg.dvd_next_addr == r_reg.lo_addr) ? 4'h0 : b[3:0];
					r_next.half = 1'b1;
					r_next.state = S_GEN_START;
				end
			end
			S_GEN_START: begin
				// Keep the partial remainder in case this pass overdraws
				r_next.adder_latch = r_reg.wp[63:32];
				r_next.lsave = r_reg.wp[31:0];
				r_next.sub_ptr = sub_top(r_reg.dvsr_len);
				r_next.flags.hot_carry = 1'b1;
				r_next.state = S_GEN;
			end
			S_GEN: begin
				r_next.wp = put_byte(r_reg.wp, r_reg.sub_ptr, sa_diff);
				r_next.flags.hot_carry = sa_cout;
				if (sa_inv) r_next.flags.invalid = 1'b1;
				if (r_reg.sub_ptr == PTR_FIRST) begin
					if (sa_cout) begin
						if (r_reg.qdigit == DIGIT_MAX) r_next.flags.invalid = 1'b1;
						else r_next.qdigit = r_reg.qdigit + 4'h1;
						r_next.state = S_GEN_START;
					end else begin
						r_next.wp = {r_reg.adder_latch, r_reg.lsave};
						r_next.state = S_DIGIT;
					end
				end else begin
					r_next.sub_ptr = r_reg.sub_ptr - 3'h1;
				end
			end
			S_DIGIT: begin
				rb = r_reg.result_byte;
				if (!r_reg.right_phase) begin
					rb[7:4] = r_reg.qdigit;
					r_next.dvd_len = r_reg.dvd_len - 4'h1;
					if ((r_reg.dvd_len - 4'h1) == r_reg.dvsr_len) begin
						rb[3:0] = (r_reg.dvd_minus ^ r_reg.flags.neg_dvsr) ? SIGN_MINUS : SIGN_PLUS;
						r_next.last_byte = 1'b1;
						r_next.req = '{valid: 1'b1, write: 1'b1, addr: r_reg.operand_addr, wdata: rb};
						r_next.state = S_STORE_Q;
					end else begin
						r_next.right_phase = 1'b1;
						r_next.state = S_SHIFT;
					end
				end else begin
					rb[3:0] = r_reg.qdigit;
					r_next.right_phase = 1'b0;
					r_next.req = '{valid: 1'b1, write: 1'b1, addr: r_reg.operand_addr, wdata: rb};
					r_next.state = S_STORE_Q;
				end
				r_next.result_byte = rb;
			end
			S_STORE_Q: begin
				if (storage_ack) begin
					r_next.operand_addr = r_reg.operand_addr + BYTE_STEP;
					r_next.q_left = r_reg.q_left - 4'h1;
					if (r_reg.last_byte) begin
						b = get_byte(rem, PTR_FIRST);
						if (r_reg.dvsr_len[2:0] == PTR_FIRST) b[3:0] = r_reg.dvd_minus ? SIGN_MINUS : SIGN_PLUS;
						r_next.store_idx = PTR_FIRST;
						r_next.req = '{valid: 1'b1, write: 1'b1, addr: r_reg.operand_addr + BYTE_STEP, wdata: b};
						r_next.state = S_STORE_R;
					end else begin
						r_next.state = S_SHIFT;
					end
				end
			end
			S_STORE_R: begin
				if (storage_ack) begin
					r_next.operand_addr = r_reg.operand_addr + BYTE_STEP;
					if (r_reg.store_idx == r_reg.dvsr_len[2:0]) begin
						r_next.done = 1'b1;
						r_next.state = S_IDLE;
					end else begin
						b = get_byte(rem, r_reg.store_idx + 3'h1);
						if ((r_reg.store_idx + 3'h1) == r_reg.dvsr_len[2:0]) b[3:0] = r_reg.dvd_minus ? SIGN_MINUS : SIGN_PLUS;
						r_next.store_idx = r_reg.store_idx + 3'h1;
						r_next.req = '{valid: 1'b1, write: 1'b1, addr: r_reg.operand_addr + BYTE_STEP, wdata: b};
					end
				end
			end
		endcase
	end

	// State register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign reg_rdata        = r_reg.rdata;
	assign storage_req      = r_reg.req;
	assign busy             = (r_reg.state != S_IDLE);
	assign divide_exception = r_reg.ovf_fault;

	// Checks on the sequencer
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	chk_dvd_pointer: assert property ((r_reg.state == S_DVD_WAIT) && storage_ack |=>
		(r_reg.bptr == $past(r_reg.dvd_next_addr[2:0])) && (r_reg.state == S_DVD_COPY))
		else $error("buffer pointer not set from dividend address");
	chk_copy_step: assert property ((r_reg.state == S_DVD_COPY) && (r_reg.dvd_len != 4'h0) |=>
		(r_reg.wptr == $past(r_reg.wptr) + 3'h1) && (r_reg.dvd_len == $past(r_reg.dvd_len) - 4'h1))
		else $error("dividend copy did not step pointers and length");
	chk_short_done: assert property ((r_reg.state == S_DVD_COPY) && (r_reg.dvd_len == 4'h0) |=>
		r_reg.state == S_RESTORE)
		else $error("dividend copy continued past zero length");
	chk_dvd_refetch: assert property ((r_reg.state == S_DVD_COPY) && (r_reg.dvd_len != 4'h0) &&
		(r_reg.wptr != PTR_LAST) && (r_reg.bptr == PTR_LAST) |=> (r_reg.state == S_DVD_WAIT) && r_reg.req.valid)
		else $error("missing dividend refetch");
	chk_len_restore: assert property ((r_reg.state == S_RESTORE) |=>
		(r_reg.len_hold[15:8] == $past(r_reg.result_byte)) ##1 (r_reg.state == S_TRIAL))
		else $error("length codes not restored");
	chk_trial_fault: assert property ((r_reg.state == S_TRIAL) && (r_reg.sub_ptr == PTR_FIRST) && sa_cout
		|=> divide_exception && !busy)
		else $error("positive trial remainder did not end instruction");
	chk_long_flag: assert property ((r_reg.state == S_SIGN) |=>
		r_reg.flags.long_dvsr == ($past(r_reg.dvsr_len) >= LEN_FIVE_BYTES))
		else $error("long divisor flag wrong");
	chk_short_flag: assert property ((r_reg.state == S_DVSR_SAVE) |=>
		r_reg.flags.short_dvd == ($past(r_reg.dvd_len) < LEN_EIGHT_BYTES))
		else $error("short dividend flag wrong");
	chk_init_copy: assert property ((r_reg.state == S_FETCH_DVSR) && storage_ack |=>
		(r_reg.bptr == PTR_LAST) && (r_reg.instr_ctr == $past(r_reg.instr_ctr) - DW_STEP))
		else $error("initialization transfers wrong");

	cov_trial_fault: cover property ((r_reg.state == S_TRIAL) ##1 divide_exception);
	cov_dvd_refetch: cover property ((r_reg.state == S_DVD_COPY) ##1 (r_reg.state == S_DVD_WAIT));
	cov_remainder:   cover property ((r_reg.state == S_STORE_R) ##[1:40] (r_reg.state == S_IDLE));

endmodule : decimal_divide_sequencer

// File: verification/storage_model.sv
// Main storage model: doubleword fetches and byte stores after a chosen delay
`timescale 1ns/1ps
module storage_model
	import divide_pkg::*;
(
	// Clock and delay
	input  wire logic         clk,
	input  wire logic [3:0]   ack_delay,
	// Storage side
	input  wire storage_req_t req,
	output logic              ack,
	output logic [63:0]       data
);
	logic [7:0] mem [256];
	logic [3:0] wait_reg = 4'h0;
	initial ack = 1'b0;
	initial data = 64'h0;
	initial foreach (mem[i]) mem[i] = 8'h00;
	// Answer a held request once the delay has run; data bus toggles when not answering
	always @(posedge clk) begin
		ack <= 1'b0;
		data <= ~data;
		if (req.valid && !ack && wait_reg < ack_delay) wait_reg <= wait_reg + 4'h1;
		else if (req.valid && !ack) begin
			ack <= 1'b1;
			wait_reg <= 4'h0;
			if (req.write) mem[req.addr[7:0]] <= req.wdata;
			for (int i = 0; i < 8; i++) data[63 - 8 * i -: 8] <= mem[{req.addr[7:3], i[2:0]}];
		end
	end
endmodule : storage_model

// File: verification/decimal_divide_sequencer_bench.sv
// Self-checking bench for the decimal divide sequencer
`timescale 1ns/1ps
module decimal_divide_sequencer_bench import divide_pkg::*;;
	logic         clk = 1'b0;
	logic         resetn = 1'b0;
	bus_req_t     reg_bus = '0;
	logic [31:0]  reg_rdata;
	storage_req_t storage_req;
	logic         storage_ack;
	logic [63:0]  storage_data_out_bus;
	logic         busy;
	logic         divide_exception;
	logic [3:0]   ack_delay = 4'h0;
	int           n_errors = 0;
	int           checks_done = 0;
	always #4 clk = ~clk;
	decimal_divide_sequencer u_dut (.clk(clk), .resetn(resetn), .reg_bus(reg_bus), .reg_rdata(reg_rdata),
		.storage_req(storage_req), .storage_ack(storage_ack), .storage_data_out_bus(storage_data_out_bus),
		.busy(busy), .divide_exception(divide_exception));
	storage_model u_mem (.clk(clk), .ack_delay(ack_delay), .req(storage_req), .ack(storage_ack),
		.data(storage_data_out_bus));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk) reg_bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk) reg_bus <= '0;
	endtask : bus_wr
	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk) reg_bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(posedge clk) reg_bus <= '0;
		#1 d = reg_rdata;
	endtask : bus_rd
	// Reset values, write-only control and an unmapped address all read zero
	task automatic test_regs;
		logic [31:0] d;
		bus_rd(REG_STATUS, d);
		chk(d, 32'h0);
		bus_rd(REG_CTRL, d);
		chk(d, 32'h0);
		bus_rd(8'hFC, d);
		chk(d, 32'h0);
	endtask : test_regs
	// Load a dividend, divide by +4 held at 0x30, then judge field, fault and status
	task automatic div_case(input logic [7:0] lens, input logic [7:0] base, input logic [127:0] dvd,
		input logic [127:0] exp, input logic exc, input logic [31:0] status_exp, input logic [3:0] dly);
		int n;
		int nb;
		logic [31:0] d;
		nb = int'(lens[7:4]) + 1;
		ack_delay = dly;
		for (int i = 0; i < nb; i++) u_mem.mem[8'(base + i)] = dvd[8 * (nb - 1 - i) +: 8];
		bus_wr(REG_LENGTHS, {24'h0, lens});
		bus_wr(REG_DVD_ADDR, {24'h0, 8'(base + nb - 1)});
		bus_wr(REG_DVSR_ADDR, 32'h30);
		bus_wr(REG_CTRL, 32'h1);
		n = 0;
		@(posedge clk);
		while (busy !== 1'b0 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		#1 chk({31'h0, busy}, 32'h0);
		chk({31'h0, divide_exception}, {31'h0, exc});
		for (int i = 0; i < nb; i++) chk({24'h0, u_mem.mem[8'(base + i)]}, {24'h0, exp[8 * (nb - 1 - i) +: 8]});
		bus_rd(REG_STATUS, d);
		chk(d & 32'h7EF, status_exp);
		bus_rd(REG_HOLD, d);
		if (status_exp[3] === 1'b0) chk({24'h0, d[23:16]}, {24'h0, lens});
	endtask : div_case
	task automatic end_sim;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_sim
	// Main sequence
	initial begin
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		u_mem.mem[8'h30] = 8'h4C;
		test_regs();
		div_case(8'h20, 8'h20, 128'h00123C, 128'h030C3C, 1'b0, 32'h502, 4'h0);
		div_case(8'h20, 8'h40, 128'h00123D, 128'h030D3D, 1'b0, 32'h502, 4'h3);
		div_case(8'h10, 8'h50, 128'h123C, 128'h123C, 1'b1, 32'h506, 4'h1);
		div_case(8'h10, 8'h52, 128'h040C, 128'h040C, 1'b1, 32'h506, 4'h0);
		div_case(8'h10, 8'h54, 128'h039C, 128'h9C3C, 1'b0, 32'h502, 4'h2);
		div_case(8'h80, 8'h5B, 128'h123C, 128'h030C3C, 1'b0, 32'h402, 4'h1);
		div_case(8'h00, 8'h70, 128'h3C, 128'h3C, 1'b0, 32'h00A, 4'h0);
		end_sim();
	end
	// Watchdog against a hung sequence
	initial begin
		#300000;
		n_errors++;
		end_sim();
	end
endmodule : decimal_divide_sequencer_bench
